// *** rtl/bcu_pkg.sv ***
// package for the branch control unit: widths, formats, opcodes, states
package bcu_pkg;
  localparam int W = 24;
  localparam int AW = 20;
  // operational states
  localparam logic [1:0] OPST_ZERO = 2'h0;
  localparam logic [1:0] OPST_ONE = 2'h1;
  localparam logic [1:0] OPST_THREE = 2'h3;
  // compatibility save word fields
  localparam int CSW_RET_LSB = 0;
  localparam int CSW_RET_W = 16;
  localparam int CSW_CC_LSB = 16;
  localparam int CSW_CC_W = 4;
  localparam int CSW_VM_BIT = 20;
  // extension save word fields
  localparam int XSW_RET_W = 20;
  // byte address increment fields
  localparam int BYTE_LSB = 22;
  localparam logic [1:0] BYTE_WRAP_SET = 2'h1;
  localparam logic [W-1:0] BYTE_FALL_LOAD = 24'h400000;
  localparam logic [8:0] BBI_OPCODE = 9'h187;
  // dedicated interrupt location and reset values
  localparam logic [AW-1:0] INT_VEC_ADDR = 20'h00020;
  localparam logic [AW-1:0] PC_RESET = 20'h00000;
  localparam logic [W-1:0] IDX_RESET = 24'h000000;
  typedef enum logic [3:0] {
    BC_NONE, BC_UNCOND, BC_COND, BC_LINK_UNR, BC_REL_USER,
    BC_SAVE, BC_SAVE_EXT, BC_RET, BC_BYTE_INC
  } bcu_op_t;
  typedef struct packed {
    bcu_op_t op;
    logic indirect;
    logic [3:0] cond_sel;
    logic [AW-1:0] ea;
    logic [8:0] opcode;
  } bcu_req_t;
  typedef struct packed {
    logic we;
    logic re;
    logic [AW-1:0] addr;
    logic [W-1:0] wdata;
  } bcu_mem_t;
endpackage : bcu_pkg

// *** rtl/bcu_branch_ctrl.sv ***
// branch control unit: branches, save words, interrupt entry and return
// Function
// - after release-user-mode, next branch of any kind except unrestricted branch-and-link enters user mode
// - unrestricted branch-and-link enters monitor mode in states zero, one, three
// - conditional branch jumps only when selected condition present
// - state zero branch-and-save leaves mode and saved-mode bit unchanged
// - compatibility save word: return 15-0, cc 19-16, vm mode 20
// - state one: user uses compatibility, monitor uses extension format
// - extension save word: return 19-0, zeros 23-20
// - state three like state zero but extension save word
// - indirect word format follows same state and mode choice
// - state zero interrupt runs hardware execute-memory of vector
// - states one, three interrupt runs hardware extended save to vector
// - every valid interrupt enters monitor mode
// - saved-mode bit captures mode only at first interrupt
// - interrupt return restores pc from save word, cc only from compatibility format
// - byte increment adds one to bits 23-22, branches if nonzero
// - on wrap set field 01, bump 21-0, zero loads octal 20000000
// - byte increment decodes opcode 607, modifies only its register
// - save writes effective address, continues at address plus one
// - interrupts held off one instruction after branch-and-save
`timescale 1ns/1ns
`default_nettype none
module bcu_branch_ctrl (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic instr_valid_in,
  input wire bcu_pkg::bcu_req_t req_in,
  input wire logic [bcu_pkg::AW-1:0] next_pc_in,
  input wire logic [3:0] cond_reg_in,
  input wire logic [1:0] op_state_in,
  input wire logic irq_in,
  input wire logic int_active_in,
  input wire logic [bcu_pkg::W-1:0] mem_rdata_in,
  input wire logic [bcu_pkg::W-1:0] index_in,
  output logic [bcu_pkg::AW-1:0] pc_out,
  output logic pc_load_out,
  output logic user_mode_out,
  output logic saved_vm_mode_bit_out,
  output logic exec_mem_out,
  output logic irq_hold_out,
  output logic [3:0] cond_restore_out,
  output logic cond_load_out,
  output logic [bcu_pkg::W-1:0] index_out,
  output logic index_load_out,
  output bcu_pkg::bcu_mem_t mem_out,
  output logic done_out
);
  import bcu_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic [AW-1:0] pc_r, pc_nxt;
  logic pc_load_r, pc_load_nxt;
  logic user_r, user_nxt;
  logic svm_r, svm_nxt;
  logic rel_pend_r, rel_pend_nxt;
  logic exm_r, exm_nxt;
  logic hold_r, hold_nxt;
  logic [3:0] cc_r, cc_nxt;
  logic cc_load_r, cc_load_nxt;
  logic [W-1:0] idx_r, idx_nxt;
  logic idx_load_r, idx_load_nxt;
  bcu_mem_t mem_r, mem_nxt;
  logic done_r, done_nxt;
  logic state_ok, ext_fmt, is_branch, take_irq;
  logic [1:0] byte_sum;
  logic [21:0] word_sum;
  logic [W-1:0] save_word;
  ////////////////////////////////////////////////////////////////////////
  // format choice by state and mode
  always_comb begin
    state_ok = (op_state_in == OPST_ZERO) || (op_state_in == OPST_ONE) ||
               (op_state_in == OPST_THREE);
    ext_fmt = (op_state_in == OPST_THREE) ||
              ((op_state_in == OPST_ONE) && !user_r);
    is_branch = instr_valid_in && (req_in.op != BC_NONE) && (req_in.op != BC_REL_USER);
    take_irq = irq_in && !hold_r && state_ok;
    byte_sum = index_in[W-1:BYTE_LSB] + 2'h1;
    word_sum = index_in[21:0] + 22'h1;
    if (ext_fmt) begin
      save_word = {{(W-XSW_RET_W){1'b0}}, next_pc_in[XSW_RET_W-1:0]};
    end else begin
      save_word = '0;
      save_word[CSW_RET_LSB +: CSW_RET_W] = next_pc_in[CSW_RET_W-1:0];
      save_word[CSW_CC_LSB +: CSW_CC_W] = cond_reg_in;
      save_word[CSW_VM_BIT] = user_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // next instruction completion state
  always_comb begin
    pc_nxt = pc_r;
    pc_load_nxt = 1'b0;
    user_nxt = user_r;
    svm_nxt = svm_r;
    rel_pend_nxt = rel_pend_r;
    exm_nxt = 1'b0;
    hold_nxt = hold_r;
    cc_nxt = cc_r;
    cc_load_nxt = 1'b0;
    idx_nxt = idx_r;
    idx_load_nxt = 1'b0;
    mem_nxt = '0;
    done_nxt = 1'b0;
    if (take_irq) begin
      if (!int_active_in) begin
        svm_nxt = user_r;
      end
      user_nxt = 1'b0;
      rel_pend_nxt = 1'b0;
      done_nxt = 1'b1;
      if (op_state_in == OPST_ZERO) begin
        exm_nxt = 1'b1;
        pc_nxt = INT_VEC_ADDR;
      end else begin
        mem_nxt.we = 1'b1;
        mem_nxt.addr = INT_VEC_ADDR;
        mem_nxt.wdata = {{(W-XSW_RET_W){1'b0}}, next_pc_in};
        pc_nxt = INT_VEC_ADDR + 20'h1;
        pc_load_nxt = 1'b1;
        hold_nxt = 1'b1;
      end
    end else if (instr_valid_in) begin
      done_nxt = 1'b1;
      hold_nxt = 1'b0;
      if (is_branch && rel_pend_r && state_ok) begin
        rel_pend_nxt = 1'b0;
        user_nxt = 1'b1;
      end
      case (req_in.op)
        BC_UNCOND: begin
          pc_nxt = req_in.ea;
          pc_load_nxt = 1'b1;
        end
        BC_COND: begin
          if ((cond_reg_in & req_in.cond_sel) != 4'h0) begin
            pc_nxt = req_in.ea;
            pc_load_nxt = 1'b1;
          end
        end
        BC_LINK_UNR: begin
          pc_nxt = req_in.ea;
          pc_load_nxt = 1'b1;
          if (state_ok) begin
            user_nxt = 1'b0;
          end
        end
        BC_REL_USER: begin
          rel_pend_nxt = 1'b1;
        end
        BC_SAVE, BC_SAVE_EXT: begin
          if (state_ok) begin
            mem_nxt.we = 1'b1;
            mem_nxt.addr = req_in.ea;
            mem_nxt.wdata = (req_in.op == BC_SAVE_EXT) ?
                            {{(W-XSW_RET_W){1'b0}}, next_pc_in} : save_word;
            pc_nxt = req_in.ea + 20'h1;
            pc_load_nxt = 1'b1;
            hold_nxt = 1'b1;
          end
        end
        BC_RET: begin
          mem_nxt.re = 1'b1;
          mem_nxt.addr = req_in.ea;
          pc_load_nxt = 1'b1;
          if (ext_fmt) begin
            pc_nxt = mem_rdata_in[XSW_RET_W-1:0];
          end else begin
            pc_nxt = {4'h0, mem_rdata_in[CSW_RET_W-1:0]};
            cc_nxt = mem_rdata_in[CSW_CC_LSB +: CSW_CC_W];
            cc_load_nxt = 1'b1;
          end
        end
        BC_BYTE_INC: begin
          if (req_in.opcode == BBI_OPCODE) begin
            idx_load_nxt = 1'b1;
            if (byte_sum != 2'h0) begin
              idx_nxt = {byte_sum, index_in[21:0]};
              pc_nxt = req_in.ea;
              pc_load_nxt = 1'b1;
            end else if (word_sum == 22'h0) begin
              idx_nxt = BYTE_FALL_LOAD;
            end else begin
              idx_nxt = {BYTE_WRAP_SET, word_sum};
              pc_nxt = req_in.ea;
              pc_load_nxt = 1'b1;
            end
          end
        end
        default: begin
          done_nxt = 1'b1;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pc_r <= PC_RESET;
      pc_load_r <= 1'b0;
      user_r <= 1'b0;
      svm_r <= 1'b0;
      rel_pend_r <= 1'b0;
      exm_r <= 1'b0;
      hold_r <= 1'b0;
      cc_r <= 4'h0;
      cc_load_r <= 1'b0;
      idx_r <= IDX_RESET;
      idx_load_r <= 1'b0;
      mem_r <= '0;
      done_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      pc_load_r <= pc_load_nxt;
      user_r <= user_nxt;
      svm_r <= svm_nxt;
      rel_pend_r <= rel_pend_nxt;
      exm_r <= exm_nxt;
      hold_r <= hold_nxt;
      cc_r <= cc_nxt;
      cc_load_r <= cc_load_nxt;
      idx_r <= idx_nxt;
      idx_load_r <= idx_load_nxt;
      mem_r <= mem_nxt;
      done_r <= done_nxt;
    end
  end
  assign pc_out = pc_r;
  assign pc_load_out = pc_load_r;
  assign user_mode_out = user_r;
  assign saved_vm_mode_bit_out = svm_r;
  assign exec_mem_out = exm_r;
  assign irq_hold_out = hold_r;
  assign cond_restore_out = cc_r;
  assign cond_load_out = cc_load_r;
  assign index_out = idx_r;
  assign index_load_out = idx_load_r;
  assign mem_out = mem_r;
  assign done_out = done_r;
endmodule : bcu_branch_ctrl
`default_nettype wire

// *** test/bcu_mem_model.sv ***
// main memory model holding save, indirect and vector words
`timescale 1ns/1ns
`default_nettype none
module bcu_mem_model (
  input wire logic sys_clk_in,
  input wire bcu_pkg::bcu_mem_t mem_in,
  input wire logic [bcu_pkg::AW-1:0] addr_in,
  output logic [bcu_pkg::W-1:0] rdata_out
);
  import bcu_pkg::*;
  logic [W-1:0] mem [1024];
  // unwritten words read as a pattern, not a stale value
  initial begin
    for (int k = 0; k < 1024; k++) begin
      mem[k] = W'(k) ^ 24'ha5a5a5;
    end
  end
  always @(posedge sys_clk_in) begin
    if (mem_in.we) begin
      mem[mem_in.addr[9:0]] <= mem_in.wdata;
    end
  end
  assign rdata_out = mem[addr_in[9:0]];
endmodule : bcu_mem_model
`default_nettype wire

// *** test/bcu_branch_ctrl_monitor.sv ***
// port checker for the branch control unit
`timescale 1ns/1ns
`default_nettype none
module bcu_branch_ctrl_monitor (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic instr_valid_in,
  input wire bcu_pkg::bcu_req_t req_in,
  input wire logic [1:0] op_state_in,
  input wire logic irq_in,
  input wire logic irq_hold_out,
  input wire logic [bcu_pkg::AW-1:0] pc_out,
  input wire logic pc_load_out,
  input wire logic user_mode_out,
  input wire logic exec_mem_out,
  input wire bcu_pkg::bcu_mem_t mem_out,
  input wire logic done_out
);
  import bcu_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  wire take = instr_valid_in && !irq_in;
  wire irq_ok = irq_in && !irq_hold_out;
  a_save_target: assert property (take && req_in.op == BC_SAVE && op_state_in == OPST_ZERO |=>
    mem_out.we && mem_out.addr == $past(req_in.ea) && pc_out == $past(req_in.ea) + 20'h1 && done_out)
    else $error("save write or target wrong");
  a_held_irq: assert property (irq_hold_out && irq_in && !instr_valid_in |=> !done_out && !exec_mem_out)
    else $error("interrupt taken while held");
  a_irq_monitor: assert property (irq_ok && op_state_in != 2'h2 |=> !user_mode_out)
    else $error("interrupt left user mode");
  a_irq_exm: assert property (irq_ok && op_state_in == OPST_ZERO |=> exec_mem_out && pc_out == INT_VEC_ADDR)
    else $error("state zero interrupt wrong");
  a_irq_ext: assert property (irq_ok && op_state_in == OPST_ONE |=>
    !exec_mem_out && mem_out.we && mem_out.addr == INT_VEC_ADDR) else $error("extended interrupt wrong");
  a_link_mon: assert property (take && req_in.op == BC_LINK_UNR && op_state_in == OPST_ZERO |=> !user_mode_out)
    else $error("link left user mode");
  a_undef_state: assert property (op_state_in == 2'h2 |=> $stable(user_mode_out))
    else $error("mode changed in undefined state");
  a_uncond_pc: assert property (take && req_in.op == BC_UNCOND && op_state_in == OPST_ZERO |=>
    pc_load_out && done_out && pc_out == $past(req_in.ea)) else $error("unconditional branch wrong");
endmodule : bcu_branch_ctrl_monitor
bind bcu_branch_ctrl bcu_branch_ctrl_monitor bcu_branch_ctrl_monitor_inst (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .instr_valid_in(instr_valid_in), .req_in(req_in), .op_state_in(op_state_in),
  .irq_in(irq_in), .irq_hold_out(irq_hold_out), .pc_out(pc_out), .pc_load_out(pc_load_out),
  .user_mode_out(user_mode_out), .exec_mem_out(exec_mem_out), .mem_out(mem_out), .done_out(done_out));
`default_nettype wire

// *** test/tb_bcu_branch_ctrl.sv ***
// self-checking testbench for the branch control unit
`timescale 1ns/1ns
`default_nettype none
module tb_bcu_branch_ctrl;
  import bcu_pkg::*;
  localparam logic [W-1:0] TIN [4] = '{24'h400005, 24'hc00005, 24'hffffff, 24'h400005};
  localparam logic [W-1:0] TEX [4] = '{24'h800005, 24'h400006, 24'h400000, 24'h400005};
  logic clk = 0, rstn = 0, vld = 0, irq = 0, act = 0;
  logic pcl, um, svm, execute_memory_op, hold, cl, il, done;
  logic [1:0] st = OPST_ZERO;
  logic [3:0] cr;
  logic [8:0] opc = BBI_OPCODE;
  logic [AW-1:0] pc;
  logic [W-1:0] rd, idx = 24'h0, idx_o;
  bcu_req_t req = '0;
  bcu_mem_t mo;
  int err_count = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  bcu_branch_ctrl bcu_branch_ctrl_inst (.sys_clk_in(clk), .rstn_in(rstn), .instr_valid_in(vld), .req_in(req),
    .next_pc_in(20'h01234), .cond_reg_in(4'ha), .op_state_in(st), .irq_in(irq), .int_active_in(act),
    .mem_rdata_in(rd), .index_in(idx), .pc_out(pc), .pc_load_out(pcl), .user_mode_out(um),
    .saved_vm_mode_bit_out(svm), .exec_mem_out(execute_memory_op), .irq_hold_out(hold), .cond_restore_out(cr),
    .cond_load_out(cl), .index_out(idx_o), .index_load_out(il), .mem_out(mo), .done_out(done));
  bcu_mem_model bcu_mem_model_inst (.sys_clk_in(clk), .mem_in(mo), .addr_in(req.ea), .rdata_out(rd));
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input bcu_op_t op, input logic [AW-1:0] ea, input logic v = 1, input logic i = 0);
    req.op = op;
    req.ea = ea;
    req.indirect = (op == BC_RET);
    req.cond_sel = 4'h1;
    req.opcode = opc;
    vld = v;
    irq = i;
    @(negedge clk);
  endtask : go
  task automatic s_save;
    go(BC_SAVE, 20'h00100);
    chk(mo.we, 1); chk(mo.addr, 20'h00100); chk(mo.wdata, 24'h0a1234);
    chk(pc, 20'h00101); chk(hold, 1);
    go(BC_NONE, 20'h0, 0, 1);
    chk(done, 0); chk(execute_memory_op, 0);
    go(BC_RET, 20'h00100);
    chk(cr, 4'ha); chk(cl, 1); chk(pc, 20'h01234);
  endtask : s_save
  task automatic s_user;
    go(BC_REL_USER, 20'h0);
    go(BC_COND, 20'h00200);
    chk(um, 1); chk(pcl, 0);
    st = OPST_ONE;
    go(BC_SAVE, 20'h00300);
    chk(mo.wdata, 24'h1a1234); chk(um, 1);
    go(BC_UNCOND, 20'h00400);
    chk(pc, 20'h00400); chk(pcl, 1);
    act = 1;
    go(BC_NONE, 20'h0, 0, 1);
    chk(um, 0); chk(svm, 0); chk(execute_memory_op, 0);
    chk(mo.addr, INT_VEC_ADDR); chk(mo.wdata, 24'h001234);
    act = 0;
    go(BC_REL_USER, 20'h0);
    go(BC_UNCOND, 20'h00410);
    go(BC_NONE, 20'h0, 0, 1);
    chk(svm, 1);
    go(BC_REL_USER, 20'h0);
    go(BC_UNCOND, 20'h00420);
    st = 2'h2;
    go(BC_LINK_UNR, 20'h00430);
    chk(um, 1);
    st = OPST_ZERO;
    go(BC_LINK_UNR, 20'h00440);
    chk(um, 0);
  endtask : s_user
  task automatic s_st3;
    st = OPST_THREE;
    go(BC_SAVE, 20'h00600);
    chk(mo.wdata, 24'h001234); chk(um, 0);
    st = OPST_ZERO;
    go(BC_UNCOND, 20'h00610);
    go(BC_NONE, 20'h0, 0, 1);
    chk(execute_memory_op, 1); chk(pc, INT_VEC_ADDR);
  endtask : s_st3
  task automatic s_byte;
    for (int k = 0; k < 4; k++) begin
      idx = TIN[k];
      opc = (k == 3) ? 9'h087 : BBI_OPCODE;
      go(BC_BYTE_INC, 20'h00700);
      chk(il, k != 3);
      if (k < 3) chk(idx_o, TEX[k]);
      if (k < 2) chk(pc, 20'h00700);
    end
  endtask : s_byte
  task automatic close_out;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    close_out;
  end
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1;
    @(negedge clk);
    chk(um, 0); chk(pc, PC_RESET);
    s_save;
    s_user;
    s_st3;
    s_byte;
    close_out;
  end
endmodule : tb_bcu_branch_ctrl
`default_nettype wire
